// ### core/eeprom_host_pkg.sv
// constants and types for the parallel eeprom page-write host controller
// Notes on behaviour
// - write starts on strobe low pulse with select low and gate high.
// - host gives next falling strobe within 150 us of previous rising strobe.
// - host keeps page address on A6..A14 at every falling strobe of a page.
// - host polls data bit 7 for completion before any new access.
package eeprom_host_pkg;
	localparam int ADDR_W        = 15;
	localparam int DATA_W        = 8;
	localparam int PAGE_BYTES    = 64;
	localparam int OFFS_W        = 6;
	localparam int CLK_PERIOD_PS = 25000;
	// bus phase lengths (ns), rounded up to cycles
	localparam int SETUP_NS      = 50;
	localparam int PULSE_NS      = 100;
	localparam int HIGH_NS       = 50;
	localparam int READ_NS       = 120;
	localparam int SETUP_CYC     = (SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PULSE_CYC     = (PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int HIGH_CYC      = (HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int READ_CYC      = (READ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// page load window, longest time, rounded down
	localparam int LOAD_US       = 150;
	localparam int LOAD_CYC      = (LOAD_US * 1000000) / CLK_PERIOD_PS;
	// poll give-up time, 10 ms
	localparam int POLL_MS       = 10;
	localparam int POLL_CYC      = (POLL_MS * 1000000) / (CLK_PERIOD_PS / 1000);
	localparam int CNT_W         = 20;
	typedef enum logic [1:0] {CMD_READ, CMD_WRITE, CMD_WRITE_LAST} cmd_t;
endpackage

// ### core/phase_if.sv
// handshake between sequencer and phase timer
`timescale 1ns/10ps
`default_nettype none
interface phase_if;
	logic        start;
	logic [19:0] len;
	logic        done;
	modport seq (output start, output len, input done);
	modport tmr (input start, input len, output done);
endinterface
`default_nettype wire

// ### core/phase_timer.sv
// down counter timing one bus phase
`timescale 1ns/10ps
`default_nettype none
module phase_timer (
	input  wire logic clk_sys,
	input  wire logic arst_n,
	phase_if.tmr      ph
);
	logic [19:0] cnt_r;
	logic        busy_r;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r  <= 20'h00000;
			busy_r <= 1'b0;
		end else if (ph.start) begin
			cnt_r  <= ph.len;
			busy_r <= 1'b1;
		end else if (busy_r) begin
			cnt_r  <= cnt_r - 20'h00001;
			busy_r <= (cnt_r != 20'h00001);
		end
	end
	assign ph.done = busy_r && (cnt_r == 20'h00001);
endmodule
`default_nettype wire

// ### core/eeprom_host.sv
// host controller driving a parallel page-write eeprom
`timescale 1ns/10ps
`default_nettype none
module eeprom_host #(
	parameter int LOAD_CYCLES = eeprom_host_pkg::LOAD_CYC,
	parameter int POLL_CYCLES = eeprom_host_pkg::POLL_CYC
) (
	// clock and reset
	input  wire logic                              clk_sys,
	input  wire logic                              arst_n,
	// user request
	input  wire logic                              req_valid,
	input  wire eeprom_host_pkg::cmd_t             req_cmd,
	input  wire logic [eeprom_host_pkg::ADDR_W-1:0] req_addr,
	input  wire logic [eeprom_host_pkg::DATA_W-1:0] req_wdata,
	output logic                                   req_ready,
	// user answer
	output logic                                   rsp_valid,
	output logic [eeprom_host_pkg::DATA_W-1:0]     rsp_rdata,
	output logic                                   rsp_timeout,
	// memory pins
	output logic                                   chip_sel_n,
	output logic                                   out_gate_n,
	output logic                                   wr_strobe_n,
	output logic [eeprom_host_pkg::ADDR_W-1:0]     mem_addr,
	output logic [eeprom_host_pkg::DATA_W-1:0]     mem_dq_o,
	output logic                                   mem_dq_oe,
	input  wire logic [eeprom_host_pkg::DATA_W-1:0] mem_dq_i
);
	import eeprom_host_pkg::*;

	// refuse timings the counters cannot hold
	if (LOAD_CYCLES < SETUP_CYC + 4 || LOAD_CYCLES >= (1 << CNT_W)) begin : g_load_chk
		$error("LOAD_CYCLES out of range");
	end
	if (POLL_CYCLES < 4 || POLL_CYCLES >= (1 << CNT_W)) begin : g_poll_chk
		$error("POLL_CYCLES out of range");
	end

	//----------------------------------------
	// state
	//----------------------------------------
	typedef enum {
		S_IDLE, S_RD_SET, S_RD_WAIT, S_WR_SET, S_WR_PULSE, S_WR_HIGH,
		S_LOAD_GAP, S_POLL_SET, S_POLL_WAIT, S_POLL_HIGH
	} state_t;

	state_t                 state_r, state_nxt;
	logic [ADDR_W-1:0]      page_r;
	logic                   page_open_r;
	logic                   last_r;
	logic [DATA_W-1:0]      last_byte_r;
	logic [CNT_W-1:0]       gap_r;
	logic [CNT_W-1:0]       poll_r;

	phase_if ph ();
	phase_timer u_timer (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.ph      (ph)
	);

	//----------------------------------------
	// decode
	//----------------------------------------
	wire idle_take   = (state_r == S_IDLE) && req_valid;
	wire is_write    = (req_cmd != CMD_READ);
	wire same_page   = (req_addr[ADDR_W-1:OFFS_W] == page_r[ADDR_W-1:OFFS_W]);
	// page change or read while loading must close the page first
	wire need_close  = page_open_r && (!is_write || !same_page);
	// no take once the gap has run out: the next strobe would miss the window
	wire gap_take    = (state_r == S_LOAD_GAP) && req_valid && is_write && same_page &&
	                   (gap_r != '0);
	wire gap_expired = (state_r == S_LOAD_GAP) && (gap_r == '0);
	wire poll_match  = (mem_dq_i[DATA_W-1] == last_byte_r[DATA_W-1]);
	wire poll_give   = (poll_r == '0);
	wire take        = (idle_take && !need_close) || gap_take;

	always_comb begin
		state_nxt = state_r;
		ph.start  = 1'b0;
		ph.len    = 20'(SETUP_CYC);
		case (state_r)
			S_IDLE: if (idle_take) begin
				ph.start = 1'b1;
				if (need_close)
					state_nxt = S_POLL_SET;
				else if (is_write)
					state_nxt = S_WR_SET;
				else
					state_nxt = S_RD_SET;
			end
			S_RD_SET: if (ph.done) begin
				ph.start  = 1'b1;
				ph.len    = 20'(READ_CYC);
				state_nxt = S_RD_WAIT;
			end
			S_RD_WAIT: if (ph.done) state_nxt = S_IDLE;
			S_WR_SET: if (ph.done) begin
				ph.start  = 1'b1;
				ph.len    = 20'(PULSE_CYC);
				state_nxt = S_WR_PULSE;
			end
			S_WR_PULSE: if (ph.done) begin
				ph.start  = 1'b1;
				ph.len    = 20'(HIGH_CYC);
				state_nxt = S_WR_HIGH;
			end
			S_WR_HIGH: if (ph.done) begin
				if (last_r) begin
					ph.start  = 1'b1;
					state_nxt = S_POLL_SET;
				end else
					state_nxt = S_LOAD_GAP;
			end
			S_LOAD_GAP: begin
				if (gap_take) begin
					ph.start  = 1'b1;
					state_nxt = S_WR_SET;
				end else if (gap_expired || (req_valid && !(is_write && same_page))) begin
					ph.start  = 1'b1;
					state_nxt = S_POLL_SET;
				end
			end
			S_POLL_SET: if (ph.done) begin
				ph.start  = 1'b1;
				ph.len    = 20'(READ_CYC);
				state_nxt = S_POLL_WAIT;
			end
			S_POLL_WAIT: if (ph.done) begin
				ph.start  = 1'b1;
				ph.len    = 20'(HIGH_CYC);
				state_nxt = (poll_match || poll_give) ? S_IDLE : S_POLL_HIGH;
			end
			S_POLL_HIGH: if (ph.done) begin
				ph.start  = 1'b1;
				state_nxt = S_POLL_SET;
			end
			default: state_nxt = S_IDLE;
		endcase
	end

	//----------------------------------------
	// pin and answer registers
	//----------------------------------------
	wire rd_phase  = (state_nxt == S_RD_SET) || (state_nxt == S_RD_WAIT);
	wire pl_phase  = (state_nxt == S_POLL_SET) || (state_nxt == S_POLL_WAIT);
	wire wr_phase  = (state_nxt == S_WR_SET) || (state_nxt == S_WR_PULSE);
	wire in_write  = wr_phase || (state_nxt == S_WR_HIGH);
	wire poll_done = (state_r == S_POLL_WAIT) && ph.done && (poll_match || poll_give);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_r     <= S_IDLE;
			chip_sel_n  <= 1'b1;
			out_gate_n  <= 1'b1;
			wr_strobe_n <= 1'b1;
			mem_addr    <= '0;
			mem_dq_o    <= '0;
			mem_dq_oe   <= 1'b0;
			req_ready   <= 1'b0;
			rsp_valid   <= 1'b0;
			rsp_rdata   <= '0;
			rsp_timeout <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			// gate high through whole write; select and strobe low in pulse
			chip_sel_n  <= !(rd_phase || pl_phase || wr_phase);
			out_gate_n  <= !(rd_phase || pl_phase) || in_write;
			wr_strobe_n <= !(state_nxt == S_WR_PULSE);
			mem_dq_oe   <= in_write;
			if (take) begin
				mem_addr <= req_addr;
				mem_dq_o <= req_wdata;
			end
			if (idle_take && need_close)
				mem_addr <= page_r;
			req_ready   <= (state_nxt == S_IDLE) || (state_nxt == S_LOAD_GAP);
			rsp_valid   <= ((state_r == S_RD_WAIT) && ph.done) ||
			               (state_r == S_WR_HIGH && ph.done && !last_r) || poll_done;
			if ((state_r == S_RD_WAIT) && ph.done)
				rsp_rdata <= mem_dq_i;
			else if (poll_done)
				rsp_rdata <= mem_dq_i;
			rsp_timeout <= poll_done && !poll_match;
		end
	end

	//----------------------------------------
	// page tracking and timers
	//----------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			page_r      <= '0;
			page_open_r <= 1'b0;
			last_r      <= 1'b0;
			last_byte_r <= '0;
		end else begin
			if (take && is_write) begin
				page_r      <= req_addr;
				page_open_r <= 1'b1;
				last_r      <= (req_cmd == CMD_WRITE_LAST);
				last_byte_r <= req_wdata;
			end else if (state_nxt == S_POLL_SET && state_r != S_POLL_HIGH) begin
				page_open_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			gap_r  <= '0;
			poll_r <= '0;
		end else begin
			// next falling strobe at the latest when device window ends
			if (state_nxt == S_LOAD_GAP && state_r != S_LOAD_GAP)
				gap_r <= CNT_W'(LOAD_CYCLES - 2 - SETUP_CYC);
			else if (gap_r != '0)
				gap_r <= gap_r - 1'b1;
			// polling gives up once POLL_CYCLES have run out
			if (state_r != S_POLL_SET && state_nxt == S_POLL_SET && state_r != S_POLL_HIGH)
				poll_r <= CNT_W'(POLL_CYCLES);
			else if (poll_r != '0)
				poll_r <= poll_r - 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### testbench/eeprom_host_chk_properties.sv
// pin-level assertions for the eeprom host controller
`timescale 1ns/10ps
`default_nettype none
module eeprom_host_chk #(
	parameter int LOAD_CYCLES = 40,
	parameter int POLL_CYCLES = 200
) (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        arst_n,
	// user side
	input wire logic        req_valid,
	input wire logic        req_ready,
	input wire logic        rsp_valid,
	// memory pins
	input wire logic        chip_sel_n,
	input wire logic        out_gate_n,
	input wire logic        wr_strobe_n,
	input wire logic [14:0] mem_addr,
	input wire logic [7:0]  mem_dq_o,
	input wire logic        mem_dq_oe
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	// cycles from a rising strobe, kept while no read has intervened
	logic        strobe_d_r;
	logic        gap_arm_r;
	int unsigned gap_cnt_r;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			strobe_d_r <= 1'b1;
			gap_arm_r  <= 1'b0;
			gap_cnt_r  <= 0;
		end else begin
			strobe_d_r <= wr_strobe_n;
			if (!out_gate_n) begin
				gap_arm_r <= 1'b0;
			end else if (wr_strobe_n && !strobe_d_r) begin
				gap_arm_r <= 1'b1;
				gap_cnt_r <= 1;
			end else begin
				gap_cnt_r <= gap_cnt_r + 1;
			end
		end
	end
	sequence low_four;
		!wr_strobe_n[*4];
	endsequence
	sequence set_before;
		$past(!chip_sel_n) && $past(mem_dq_oe);
	endsequence
	wr_level_a: assert property (!wr_strobe_n |-> !chip_sel_n && out_gate_n)
		else $error("strobe low with bad levels");
	wr_width_a: assert property ($fell(wr_strobe_n) |-> low_four)
		else $error("strobe pulse short");
	wr_setup_a: assert property ($fell(wr_strobe_n) |-> set_before)
		else $error("select or data late");
	bus_hold_a: assert property (!wr_strobe_n ##1 !wr_strobe_n |-> $stable(mem_addr) && $stable(mem_dq_o))
		else $error("bus moved in strobe");
	data_own_a: assert property ($rose(wr_strobe_n) |-> $past(mem_dq_oe))
		else $error("data dropped early");
	no_clash_a: assert property (!out_gate_n |-> !mem_dq_oe && wr_strobe_n)
		else $error("drive during read");
	take_drop_a: assert property (req_valid && req_ready |=> !req_ready)
		else $error("ready held after take");
	rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
		else $error("answer too long");
	gap_keep_a: assert property (gap_arm_r && $fell(wr_strobe_n) |-> gap_cnt_r <= LOAD_CYCLES)
		else $error("page load gap too long");
endmodule
bind eeprom_host eeprom_host_chk #(.LOAD_CYCLES(LOAD_CYCLES), .POLL_CYCLES(POLL_CYCLES)) chk (
	.clk_sys(clk_sys), .arst_n(arst_n), .req_valid(req_valid), .req_ready(req_ready),
	.rsp_valid(rsp_valid), .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n),
	.wr_strobe_n(wr_strobe_n), .mem_addr(mem_addr), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe));
`default_nettype wire

// ### testbench/eeprom_dev_model.sv
// behavioural paged eeprom seen at the host pins
`timescale 1ns/10ps
`default_nettype none
module eeprom_dev_model #(
	parameter int LOAD_NS = 1000,
	parameter int PROG_NS = 2000
) (
	// control pins
	input  wire logic        cs_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	// address and data
	input  wire logic [14:0] addr,
	input  wire logic [7:0]  din,
	output logic [7:0]       dout
);
	logic [7:0]  mem [0:32767];
	logic [7:0]  pg [0:63];
	logic [63:0] ld = '0;
	logic [14:0] lat_a;
	logic [7:0]  q;
	logic [7:0]  held = 8'h00;
	logic        busy = 1'b0;
	realtime     t_up = 0;
	wire         wr = !cs_n && !we_n && oe_n && !busy;
	wire         rd = !cs_n && !oe_n && we_n;
	initial for (int i = 0; i < 32768; i++) mem[i] = i[7:0] ^ 8'h5A;
	always @(posedge wr) lat_a = addr;
	always @(negedge wr) begin
		pg[lat_a[5:0]] = din;
		ld[lat_a[5:0]] = 1'b1;
		t_up = $realtime;
	end
	// write in progress: last byte shows inverted top bit
	assign q = ((busy || |ld) && addr == lat_a) ? {~pg[lat_a[5:0]][7], pg[lat_a[5:0]][6:0]}
		: mem[addr];
	always @(rd or q) if (rd) held = q;
	assign dout = rd ? q : ~held;
	initial forever begin
		#10;
		if (|ld && !wr && $realtime - t_up > LOAD_NS) begin
			busy = 1'b1;
			#PROG_NS;
			for (int i = 0; i < 64; i++) if (ld[i]) mem[{lat_a[14:6], i[5:0]}] = pg[i];
			ld = '0;
			busy = 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### testbench/eeprom_host_tb.sv
// self-checking bench for the eeprom host controller
`timescale 1ns/10ps
`default_nettype none
module eeprom_host_tb;
	import eeprom_host_pkg::*;
	typedef struct {cmd_t cmd; logic [14:0] a; logic [7:0] d;} row_t;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic req_valid = 1'b0;
	cmd_t req_cmd = CMD_READ;
	logic [14:0] req_addr = '0;
	logic [7:0] req_wdata = '0;
	logic req_ready, rsp_valid, rsp_timeout, cs_n, oe_n, we_n, dq_oe;
	logic [7:0] rsp_rdata, dq_o, dev_q;
	logic [14:0] mem_addr;
	wire [7:0] bus = dq_oe ? dq_o : dev_q;
	int failures = 0;
	int comparisons = 0;
	// page the bench believes is still loading in the device
	logic pg_open = 1'b0;
	logic [14:0] pg_addr = '0;
	logic [7:0] pg_data = '0;
	// reads carry the expected byte; unwritten bytes hold addr ^ 5A
	row_t rows [15] = '{'{CMD_READ, 15'h0123, 8'h79}, '{CMD_WRITE_LAST, 15'h0123, 8'hC3},
		'{CMD_READ, 15'h0123, 8'hC3}, '{CMD_READ, 15'h7FFF, 8'hA5},
		'{CMD_WRITE, 15'h01C5, 8'h11}, '{CMD_WRITE, 15'h01C2, 8'h22},
		'{CMD_WRITE, 15'h01C5, 8'h33}, '{CMD_WRITE_LAST, 15'h01FF, 8'h44},
		'{CMD_READ, 15'h01C5, 8'h33}, '{CMD_READ, 15'h01FF, 8'h44},
		'{CMD_READ, 15'h01C6, 8'h9C}, '{CMD_WRITE, 15'h0200, 8'h55},
		'{CMD_WRITE_LAST, 15'h4000, 8'h66}, '{CMD_READ, 15'h0200, 8'h55},
		'{CMD_READ, 15'h4000, 8'h66}};
	eeprom_host #(.LOAD_CYCLES(40), .POLL_CYCLES(200)) dut (.clk_sys(clk_sys), .arst_n(arst_n),
		.req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.rsp_timeout(rsp_timeout), .chip_sel_n(cs_n), .out_gate_n(oe_n), .wr_strobe_n(we_n),
		.mem_addr(mem_addr), .mem_dq_o(dq_o), .mem_dq_oe(dq_oe), .mem_dq_i(bus));
	eeprom_dev_model dev (.cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .addr(mem_addr), .din(bus),
		.dout(dev_q));
	initial forever #12.5 clk_sys = ~clk_sys;
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic do_req(input cmd_t c, input logic [14:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		logic close_first;
		// a read or a foreign page first closes the open page; request is re-presented
		close_first = pg_open && (c == CMD_READ || a[14:6] != pg_addr[14:6]);
		repeat (close_first ? 2 : 1) begin
			n = 0;
			@(posedge clk_sys);
			#2;
			req_cmd = c;
			req_addr = a;
			req_wdata = d;
			req_valid = 1'b1;
			do @(negedge clk_sys); while (req_ready !== 1'b1 && ++n < 900);
			@(posedge clk_sys);
			#2 req_valid = 1'b0;
			do @(negedge clk_sys); while (rsp_valid !== 1'b1 && ++n < 1800);
			q = rsp_rdata;
			check({rsp_valid, rsp_timeout}, 8'h02, "answer flags");
			if (close_first) check(q, pg_data, "page close");
			close_first = 1'b0;
		end
		pg_open = (c == CMD_WRITE);
		pg_addr = a;
		pg_data = d;
	endtask
	task automatic end_of_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		end_of_test();
	end
	initial begin
		logic [7:0] q;
		repeat (6) @(posedge clk_sys);
		#2 arst_n = 1'b1;
		repeat (2) @(posedge clk_sys);
		foreach (rows[i]) begin
			do_req(rows[i].cmd, rows[i].a, rows[i].d, q);
			if (rows[i].cmd == CMD_READ) check(q, rows[i].d, "read");
			if (rows[i].cmd == CMD_WRITE_LAST) check(q, rows[i].d, "polled byte");
			$display("row %0d done", i);
		end
		// page left open must close on its own after the load gap
		do_req(CMD_WRITE, 15'h0300, 8'h88, q);
		repeat (400) @(posedge clk_sys);
		// gap has expired, the controller closed the page on its own
		pg_open = 1'b0;
		do_req(CMD_READ, 15'h0300, 8'h00, q);
		check(q, 8'h88, "gap close");
		$display("gap test done");
		// reset in mid write
		fork
			do_req(CMD_WRITE_LAST, 15'h0400, 8'hAA, q);
		join_none
		repeat (6) @(posedge clk_sys);
		#2 arst_n = 1'b0;
		disable fork;
		req_valid = 1'b0;
		#5 check({cs_n, oe_n, we_n, dq_oe, req_ready}, 8'h1C, "reset pins");
		repeat (6) @(posedge clk_sys);
		#2 arst_n = 1'b1;
		repeat (200) @(posedge clk_sys);
		do_req(CMD_READ, 15'h0123, 8'h00, q);
		check(q, 8'hC3, "after reset");
		$display("reset test done");
		end_of_test();
	end
endmodule
`default_nettype wire
